// ---- core/msp_pkg.sv ----
// Constants and types shared by the multi-lane SPI pad configuration block
`default_nettype none
package msp_pkg;
  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] MSP_OFS_DEVCFG = 12'h000;
  localparam logic [11:0] MSP_OFS_XIPCFG = 12'h004;
  localparam logic [11:0] MSP_OFS_PADOE = 12'h008;
  localparam logic [11:0] MSP_OFS_STATUS = 12'h00c;
  // ==========================================================
  // Field layouts and reset values
  localparam int MSP_WCS_W = 4;
  localparam int MSP_SEPIO_POS = 4;
  localparam int MSP_MIX_W = 3;
  localparam int MSP_OE_W = 10;
  localparam int MSP_CLK_PAD = 8;
  localparam int MSP_DM_PAD = 9;
  localparam logic [3:0] MSP_WCS_RST = 4'h0;
  localparam logic [2:0] MSP_MIX_RST = 3'h0;
  localparam logic [9:0] MSP_OE_RST = 10'h000;
  // Packed config word carried to the link domain
  localparam int MSP_CW_W = 18;
  localparam int MSP_CW_SEPIO = 4;
  localparam int MSP_CW_MIX = 5;
  localparam int MSP_CW_OE = 8;
  localparam logic [17:0] MSP_CW_RST = 18'h00000;
  // ==========================================================
  // Width-and-chip-enable codes
  localparam logic [3:0] MSP_SINGLE_LANE_CS0 = 4'h1;
  localparam logic [3:0] MSP_SINGLE_LANE_CS1 = 4'h2;
  localparam logic [3:0] MSP_TWO_LANE_CS0 = 4'h5;
  localparam logic [3:0] MSP_TWO_LANE_CS1 = 4'h6;
  localparam logic [3:0] MSP_FOUR_LANE_CS0 = 4'h9;
  localparam logic [3:0] MSP_FOUR_LANE_CS1 = 4'ha;
  localparam logic [3:0] MSP_EIGHT_LANE_CS0 = 4'hd;
  localparam logic [3:0] MSP_EIGHT_LANE_CS1 = 4'he;
  // Mixed-phase codes: bit0 enable, bit1 address too, bit2 four lanes
  localparam logic [2:0] MSP_MIX_NORMAL = 3'h0;
  localparam logic [2:0] MSP_TWO_LANE_DATA_PHASE = 3'h1;
  localparam logic [2:0] MSP_TWO_LANE_ADDR_DATA_PHASE = 3'h3;
  localparam logic [2:0] MSP_FOUR_LANE_DATA_PHASE = 3'h5;
  localparam logic [2:0] MSP_FOUR_LANE_ADDR_DATA_PHASE = 3'h7;
  // Lanes in use per width
  localparam logic [7:0] MSP_MASK_SERIAL = 8'h03;
  localparam logic [7:0] MSP_MASK_DUAL = 8'h03;
  localparam logic [7:0] MSP_MASK_QUAD = 8'h0f;
  localparam logic [7:0] MSP_MASK_OCTAL = 8'hff;

  typedef enum logic [1:0] {
    MSP_W_SERIAL = 2'b00,
    MSP_W_DUAL = 2'b01,
    MSP_W_QUAD = 2'b10,
    MSP_W_OCTAL = 2'b11
  } msp_width_t;

  typedef enum logic [1:0] {
    MSP_PH_INSTR = 2'b00,
    MSP_PH_ADDR = 2'b01,
    MSP_PH_DATA = 2'b11,
    MSP_PH_IDLE = 2'b10
  } msp_phase_t;
endpackage
`default_nettype wire

// ---- core/msp_word_sync.sv ----
// Toggle handshake that carries one word between two clock domains
`default_nettype none
module msp_word_sync #(
  parameter int W = 18,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic src_clk, // Sending domain clock
  input wire logic src_rst_n, // Sending domain reset, low
  input wire logic src_load, // Pulse: take src_data
  input wire logic [W-1:0] src_data, // Word to send
  output logic src_busy, // Word in flight
  input wire logic dst_clk, // Receiving domain clock
  input wire logic dst_rst_n, // Receiving domain reset, low
  output logic [W-1:0] dst_data, // Word as received
  output logic dst_update // Pulse: dst_data just changed
);
  logic [W-1:0] hold_q;
  logic req_q, ack_s1_q, ack_s2_q;
  logic req_s1_q, req_s2_q, ack_q;

  // ==========================================================
  // Sending side: word held still while the toggle is in flight
  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      hold_q <= RST_VAL;
      req_q <= 1'b0;
    end else if (src_load && !src_busy) begin
      hold_q <= src_data;
      req_q <= ~req_q;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= ack_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  assign src_busy = req_q ^ ack_s2_q;

  // ==========================================================
  // Receiving side
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
    end
  end

  // Sampling hold_q is safe: it cannot move until ack returns
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      dst_data <= RST_VAL;
      ack_q <= 1'b0;
      dst_update <= 1'b0;
    end else begin
      dst_update <= req_s2_q ^ ack_q;
      if (req_s2_q ^ ack_q) begin
        dst_data <= hold_q;
        ack_q <= req_s2_q;
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/msp_pad_config.sv ----
// Pad and mode configuration for one multi-lane SPI master instance
//
// How it works
// - Serial, dual, quad, octal on either chip enable.
// - Serial: lane0 output only, lane1 input only.
// - Clock output only, driven while its enable bit is set; strobe two-way in octal only.
// - Separate-IO bit feeds pad1 into receive bit0.
// - Width field jointly encodes lane count and chip enable.
// - Mixed field: none, dual/quad data, address too.
// - Instruction at base width, then mixed width follows.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`default_nettype none
module msp_pad_config (
  input wire logic clock, // Register clock, 200 MHz
  input wire logic resetn, // Synchronous reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction, high writes
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready, always high
  output logic pslverr, // APB error on unmapped address
  input wire logic link_clk, // Interface-side clock
  input wire logic eng_cs_active, // Engine: transfer in progress
  input wire msp_pkg::msp_phase_t eng_phase, // Engine: current phase
  input wire logic eng_dma_xip, // Engine: DMA or execute-in-place op
  input wire logic [7:0] eng_dq_out, // Engine: lane output data
  input wire logic eng_dq_drive, // Engine: lanes should drive
  input wire logic eng_sck, // Engine: interface clock level
  input wire logic eng_dm_out, // Engine: mask/strobe output
  input wire logic eng_dm_drive, // Engine: mask/strobe should drive
  output msp_pkg::msp_width_t lane_width, // Width now in effect
  output logic [7:0] rx_dq, // Receive data to capture logic
  output logic rx_dm, // Receive mask/strobe level
  output logic pad_cs0_n, // Chip enable 0, low active
  output logic pad_cs1_n, // Chip enable 1, low active
  output logic pad_sck_o, // Interface clock pad output
  output logic pad_sck_oe_n, // Interface clock enable, low drives
  output logic [7:0] pad_dq_o, // Data lane pad outputs
  output logic [7:0] pad_dq_oe_n, // Data lane enables, low drives
  input wire logic [7:0] pad_dq_i, // Data lane pad inputs
  output logic pad_dm_o, // Mask/strobe pad output
  output logic pad_dm_oe_n, // Mask/strobe enable, low drives
  input wire logic pad_dm_i // Mask/strobe pad input
);
  import msp_pkg::*;

  // ==========================================================
  // Register bank
  logic [3:0] wcs_q;
  logic sepio_q;
  logic [2:0] mix_q;
  logic [9:0] oe_q;
  logic dirty_q;
  logic cfg_busy;
  logic wr_en, setup, mapped, cfg_wr;
  logic [31:0] rd_d;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped;
  assign mapped = paddr == MSP_OFS_DEVCFG || paddr == MSP_OFS_XIPCFG ||
                  paddr == MSP_OFS_PADOE || paddr == MSP_OFS_STATUS;
  assign cfg_wr = wr_en && paddr != MSP_OFS_STATUS;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      wcs_q <= MSP_WCS_RST;
      sepio_q <= 1'b0;
    end else if (wr_en && paddr == MSP_OFS_DEVCFG) begin
      wcs_q <= pwdata[MSP_WCS_W-1:0];
      sepio_q <= pwdata[MSP_SEPIO_POS];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      mix_q <= MSP_MIX_RST;
    end else if (wr_en && paddr == MSP_OFS_XIPCFG) begin
      mix_q <= pwdata[MSP_MIX_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      oe_q <= MSP_OE_RST;
    end else if (wr_en && paddr == MSP_OFS_PADOE) begin
      oe_q <= pwdata[MSP_OE_W-1:0];
    end
  end

  // A write landing while the last word is still in flight is not lost
  always_ff @(posedge clock) begin
    if (!resetn) begin
      dirty_q <= 1'b0;
    end else if (cfg_wr) begin
      dirty_q <= 1'b1;
    end else if (!cfg_busy) begin
      dirty_q <= 1'b0;
    end
  end

  always_comb begin
    rd_d = 32'h00000000;
    unique case (paddr)
      MSP_OFS_DEVCFG: rd_d = {27'h0, sepio_q, wcs_q};
      MSP_OFS_XIPCFG: rd_d = {29'h0, mix_q};
      MSP_OFS_PADOE: rd_d = {22'h0, oe_q};
      MSP_OFS_STATUS: rd_d = {27'h0, wcs_q[1:0] == 2'b00 ||
                              wcs_q[1:0] == 2'b11, wcs_q[3:2],
                              dirty_q, cfg_busy};
      default: rd_d = 32'h00000000;
    endcase
  end

  // Read data is latched in the setup cycle for a zero-wait access
  always_ff @(posedge clock) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // ==========================================================
  // Crossing into the link domain
  logic rst_l1_q, rst_l2_q;
  logic [MSP_CW_W-1:0] cw;
  logic cw_upd;

  always_ff @(posedge link_clk) begin
    rst_l1_q <= resetn;
    rst_l2_q <= rst_l1_q;
  end

  msp_word_sync #(.W(MSP_CW_W), .RST_VAL(MSP_CW_RST)) u_sync (
    .src_clk(clock),
    .src_rst_n(resetn),
    .src_load(dirty_q),
    .src_data({oe_q, mix_q, sepio_q, wcs_q}),
    .src_busy(cfg_busy),
    .dst_clk(link_clk),
    .dst_rst_n(rst_l2_q),
    .dst_data(cw),
    .dst_update(cw_upd)
  );

  // ==========================================================
  // Link-side decode
  msp_width_t base_w, eff_w;
  logic [2:0] mix;
  logic [9:0] oe;
  logic sepio, cs_sel0, cs_sel1;
  logic [7:0] lane_mask, drive;

  assign base_w = msp_width_t'(cw[3:2]);
  assign sepio = cw[MSP_CW_SEPIO];
  assign mix = cw[MSP_CW_MIX +: MSP_MIX_W];
  assign oe = cw[MSP_CW_OE +: MSP_OE_W];
  // Low bits 00 or 11 select no chip enable
  assign cs_sel0 = cw[1:0] == 2'b01;
  assign cs_sel1 = cw[1:0] == 2'b10;

  // Mixed widths apply only to DMA and XIP traffic, never to the opcode
  always_comb begin
    eff_w = base_w;
    if (eng_dma_xip && mix[0] && (eng_phase == MSP_PH_DATA ||
        (eng_phase == MSP_PH_ADDR && mix[1]))) begin
      eff_w = mix[2] ? MSP_W_QUAD : MSP_W_DUAL;
    end
  end

  always_comb begin
    unique case (eff_w)
      MSP_W_SERIAL: lane_mask = MSP_MASK_SERIAL;
      MSP_W_DUAL: lane_mask = MSP_MASK_DUAL;
      MSP_W_QUAD: lane_mask = MSP_MASK_QUAD;
      MSP_W_OCTAL: lane_mask = MSP_MASK_OCTAL;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_lane
      if (g == 0) begin : g_l0
        // Serial lane 0 is a plain output, never turned round
        assign drive[g] = oe[g] && ((eff_w == MSP_W_SERIAL) ||
                          (lane_mask[g] && eng_dq_drive));
      end else if (g == 1) begin : g_l1
        assign drive[g] = oe[g] && eff_w != MSP_W_SERIAL &&
                          lane_mask[g] && eng_dq_drive;
      end else begin : g_ln
        assign drive[g] = oe[g] && lane_mask[g] && eng_dq_drive;
      end
    end
  endgenerate

  // ==========================================================
  // Pad drivers, all registered on the link clock
  always_ff @(posedge link_clk) begin
    if (!rst_l2_q) begin
      pad_dq_o <= 8'h00;
      pad_dq_oe_n <= 8'hff;
      lane_width <= MSP_W_SERIAL;
    end else begin
      pad_dq_o <= eng_dq_out;
      pad_dq_oe_n <= ~drive;
      lane_width <= eff_w;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!rst_l2_q) begin
      pad_sck_o <= 1'b0;
      pad_sck_oe_n <= 1'b1;
    end else begin
      pad_sck_o <= eng_sck;
      pad_sck_oe_n <= ~oe[MSP_CLK_PAD];
    end
  end

  always_ff @(posedge link_clk) begin
    if (!rst_l2_q) begin
      pad_dm_o <= 1'b0;
      pad_dm_oe_n <= 1'b1;
    end else begin
      pad_dm_o <= eng_dm_out;
      pad_dm_oe_n <= ~(oe[MSP_DM_PAD] && base_w == MSP_W_OCTAL &&
                       eng_dm_drive);
    end
  end

  always_ff @(posedge link_clk) begin
    if (!rst_l2_q) begin
      pad_cs0_n <= 1'b1;
      pad_cs1_n <= 1'b1;
    end else begin
      pad_cs0_n <= ~(eng_cs_active && cs_sel0);
      pad_cs1_n <= ~(eng_cs_active && cs_sel1);
    end
  end

  // ==========================================================
  // Receive path: pads are asynchronous, two flops before any use
  logic [8:0] in_s1_q, in_s2_q;
  always_ff @(posedge link_clk) begin
    if (!rst_l2_q) begin
      in_s1_q <= 9'h000;
      in_s2_q <= 9'h000;
    end else begin
      in_s1_q <= {pad_dm_i, pad_dq_i};
      in_s2_q <= in_s1_q;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!rst_l2_q) begin
      rx_dq <= 8'h00;
      rx_dm <= 1'b0;
    end else begin
      rx_dq <= {in_s2_q[7:1], sepio ? in_s2_q[1] : in_s2_q[0]};
      rx_dm <= in_s2_q[8];
    end
  end

  // ==========================================================
  // Checks
  property p_lane1_input;
    @(posedge link_clk) disable iff (!rst_l2_q)
    $past(eff_w == MSP_W_SERIAL && rst_l2_q) |-> pad_dq_oe_n[1];
  endproperty
  a_lane1_input: assert property (p_lane1_input)
    else $error("lane 1 driven in serial width");
  property p_lane0_output;
    @(posedge link_clk) disable iff (!rst_l2_q)
    $past(eff_w == MSP_W_SERIAL && oe[0] && rst_l2_q) |-> !pad_dq_oe_n[0];
  endproperty
  a_lane0_output: assert property (p_lane0_output)
    else $error("serial lane 0 not driven");
  property p_clock_out;
    @(posedge link_clk) disable iff (!rst_l2_q)
    $past(rst_l2_q) |-> pad_sck_oe_n == !$past(oe[MSP_CLK_PAD]);
  endproperty
  a_clock_out: assert property (p_clock_out)
    else $error("clock pad enable does not follow its bit");
  property p_strobe_octal;
    @(posedge link_clk) disable iff (!rst_l2_q)
    !pad_dm_oe_n |-> $past(base_w) == MSP_W_OCTAL;
  endproperty
  a_strobe_octal: assert property (p_strobe_octal)
    else $error("strobe driven outside octal width");
  property p_sep_io;
    @(posedge link_clk) disable iff (!rst_l2_q)
    sepio && !cw_upd ##1 rst_l2_q |-> rx_dq[0] == $past(in_s2_q[1]);
  endproperty
  a_sep_io: assert property (p_sep_io)
    else $error("receive bit 0 not taken from pad 1");
  property p_upper_lanes;
    @(posedge link_clk) disable iff (!rst_l2_q)
    pad_dq_oe_n[7:4] != 4'hf |-> $past(base_w) == MSP_W_OCTAL;
  endproperty
  a_upper_lanes: assert property (p_upper_lanes)
    else $error("upper lanes driven below octal width");
  sequence s_serial_opcode;
    eng_phase == MSP_PH_INSTR && base_w == MSP_W_SERIAL;
  endsequence
  property p_opcode_base;
    @(posedge link_clk) disable iff (!rst_l2_q)
    s_serial_opcode ##1 rst_l2_q |-> pad_dq_oe_n[7:1] == 7'h7f;
  endproperty
  a_opcode_base: assert property (p_opcode_base)
    else $error("opcode sent wider than base width");
  property p_mixed_data;
    @(posedge link_clk) disable iff (!rst_l2_q)
    eng_dma_xip && eng_phase == MSP_PH_DATA && mix == 3'h5 ##1 rst_l2_q
      |-> lane_width == MSP_W_QUAD;
  endproperty
  a_mixed_data: assert property (p_mixed_data)
    else $error("four-lane data phase not applied");
  property p_cs_select;
    @(posedge link_clk) disable iff (!rst_l2_q)
    !pad_cs1_n |-> $past(cw[1:0]) == 2'b10 && pad_cs0_n;
  endproperty
  a_cs_select: assert property (p_cs_select)
    else $error("chip enable 1 without its code");
  property p_cfg_busy;
    @(posedge clock) disable iff (!resetn)
    cfg_wr && !cfg_busy |=> ##[0:2] cfg_busy;
  endproperty
  a_cfg_busy: assert property (p_cfg_busy)
    else $error("config write never sent to link side");
endmodule
`default_nettype wire

// ---- verif/msp_mem_model.sv ----
// Behavioural external memory device on the pad side of the block
`default_nettype none
module msp_mem_model (
  input wire logic link_clk, // Interface-side clock
  input wire logic pad_cs0_n, // Chip enable 0, low active
  input wire logic pad_cs1_n, // Chip enable 1, low active
  input wire logic pad_sck_o, // Interface clock from the block
  input wire logic [7:0] pad_dq_o, // Lane outputs of the block
  input wire logic [7:0] pad_dq_oe_n, // Lane enables, low drives
  input wire logic pad_dm_o, // Strobe output of the block
  input wire logic pad_dm_oe_n, // Strobe enable, low drives
  input wire logic resp_en, // Answer while selected
  input wire logic [7:0] resp_dq, // Lane values to answer with
  output logic [7:0] pad_dq_i, // Resolved lane levels
  output logic pad_dm_i // Resolved strobe level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Line resolution
  logic sel;
  logic [7:0] idle_q = 8'h5a;
  logic dm_idle_q = 1'b0;
  assign sel = !(pad_cs0_n && pad_cs1_n);
  // Released lines keep changing, so a stale level can never pass
  always @(posedge link_clk) begin
    idle_q <= ~pad_dq_i;
    dm_idle_q <= ~pad_dm_i;
  end
  // The device only answers on lanes the block has released
  assign pad_dq_i = (~pad_dq_oe_n & pad_dq_o) |
    (pad_dq_oe_n & ((sel && resp_en) ? resp_dq : idle_q));
  assign pad_dm_i = pad_dm_oe_n ? dm_idle_q : pad_dm_o;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the pad configuration block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import msp_pkg::*;
  logic clock = 1'b0;
  logic link_clk = 1'b0;
  logic resetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic eng_cs_active, eng_dma_xip, eng_dq_drive, eng_sck, eng_dm_out;
  logic eng_dm_drive, rx_dm, pad_cs0_n, pad_cs1_n, pad_sck_o;
  logic pad_sck_oe_n, pad_dm_o, pad_dm_oe_n, pad_dm_i, resp_en;
  logic [7:0] eng_dq_out, rx_dq, pad_dq_o, pad_dq_oe_n, pad_dq_i, resp_dq;
  msp_phase_t eng_phase;
  msp_width_t lane_width;
  int failures = 0;
  int cmp_count = 0;
  logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'ha, 4'hd, 4'he};
  logic [7:0] lm [4] = '{8'h01, 8'h03, 8'h0f, 8'hff};
  logic [31:0] fmask [3] = '{32'h1f, 32'h7, 32'h3ff};
  logic [31:0] oes [3] = '{32'h101, 32'h200, 32'h0f0};
  logic [2:0] mixes [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
  msp_phase_t phs [3] = '{MSP_PH_INSTR, MSP_PH_ADDR, MSP_PH_DATA};
  logic [1:0] w;
  logic [7:0] m;
  logic [2:0] x;

  msp_pad_config dut_u (
    .clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .link_clk, .eng_cs_active, .eng_phase,
    .eng_dma_xip, .eng_dq_out, .eng_dq_drive, .eng_sck, .eng_dm_out,
    .eng_dm_drive, .lane_width, .rx_dq, .rx_dm, .pad_cs0_n, .pad_cs1_n,
    .pad_sck_o, .pad_sck_oe_n, .pad_dq_o, .pad_dq_oe_n, .pad_dq_i,
    .pad_dm_o, .pad_dm_oe_n, .pad_dm_i
  );
  msp_mem_model mem_u (
    .link_clk, .pad_cs0_n, .pad_cs1_n,
    .pad_sck_o,
    .pad_dq_o, .pad_dq_oe_n, .pad_dm_o, .pad_dm_oe_n, .resp_en, .resp_dq,
    .pad_dq_i, .pad_dm_i
  );

  // ==========================================================
  // Clocks and closing
  always #2.5 clock = ~clock;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    wrap_up();
  end

  // ==========================================================
  // Access tasks
  task automatic apb(logic [11:0] a, logic wr, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 64);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", pready, 1'b1);
  endtask

  task automatic lw(int n);
    repeat (n) @(posedge link_clk);
    @(negedge link_clk);
  endtask

  // Writes a setting and waits until the link side has taken it
  task automatic cfg(logic [31:0] dc, logic [31:0] mx, logic [31:0] oe);
    int n;
    n = 0;
    apb(MSP_OFS_DEVCFG, 1'b1, dc);
    apb(MSP_OFS_XIPCFG, 1'b1, mx);
    apb(MSP_OFS_PADOE, 1'b1, oe);
    do begin
      apb(MSP_OFS_STATUS, 1'b0, 32'h0);
      n++;
    end while (r[1:0] !== 2'b00 && n < 100);
    chk("crossing idle", r[1:0], 2'b00);
    lw(6);
  endtask

  task automatic eng(msp_phase_t ph, logic xip, logic drv);
    @(posedge link_clk);
    eng_cs_active <= 1'b1;
    eng_phase <= ph;
    eng_dma_xip <= xip;
    eng_dq_drive <= drv;
    eng_dm_drive <= drv;
    lw(4);
  endtask

  // ==========================================================
  // Tests
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    eng_cs_active = 1'b0;
    eng_phase = MSP_PH_IDLE;
    eng_dma_xip = 1'b0;
    eng_dq_out = 8'h01;
    eng_dq_drive = 1'b0;
    eng_sck = 1'b1;
    eng_dm_out = 1'b1;
    eng_dm_drive = 1'b0;
    resp_en = 1'b1;
    resp_dq = 8'ha4;
    // Link reset is resynchronised, so it needs a few slow edges too
    repeat (16) @(posedge clock);
    repeat (3) @(posedge link_clk);
    @(posedge clock);
    resetn <= 1'b1;
    lw(4);
    chk("cs0 idle", pad_cs0_n, 1'b1);
    chk("lanes idle", pad_dq_oe_n, 8'hff);
    for (int i = 0; i < 4; i++) begin
      apb(12'(4 * i), 1'b0, 32'h0);
      // Status reports code 0 as selecting no chip enable
      chk("reset value", r, i == 3 ? 32'h10 : 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      apb(12'(4 * i), 1'b1, 32'hffffffff);
      apb(12'(4 * i), 1'b0, 32'h0);
      chk("field width", r, fmask[i]);
    end
    apb(12'h010, 1'b1, 32'h0);
    chk("unmapped error", e, 1'b1);
    apb(MSP_OFS_PADOE, 1'b0, 32'h0);
    chk("unmapped no effect", r, 32'h3ff);
    chk("mapped no error", e, 1'b0);
    // Every width code, lanes asked to drive and to float
    foreach (codes[i]) begin
      cfg({28'h0, codes[i]}, 32'h0, 32'h3ff);
      chk("status code", r, {28'h0, codes[i][3:2], 2'b00});
      w = codes[i][3:2];
      for (int d = 0; d < 2; d++) begin
        eng(MSP_PH_DATA, 1'b0, d[0]);
        m = (w == 2'd0 || d == 1) ? lm[w] : 8'h00;
        chk("width", lane_width, w);
        chk("lane drive", pad_dq_oe_n, 8'(~m));
        chk("cs0", pad_cs0_n, codes[i][1:0] != 2'b01);
        chk("cs1", pad_cs1_n, codes[i][1:0] != 2'b10);
        chk("clock drive", pad_sck_oe_n, 1'b0);
        chk("strobe", pad_dm_oe_n, !(w == 2'd3 && d == 1));
      end
    end
    foreach (oes[i]) begin
      cfg(32'hd, 32'h0, oes[i]);
      eng(MSP_PH_DATA, 1'b0, 1'b1);
      chk("lane gate", pad_dq_oe_n, 8'(~oes[i][7:0]));
      chk("clock gate", pad_sck_oe_n, 1'(~oes[i][8]));
      chk("strobe gate", pad_dm_oe_n, 1'(~oes[i][9]));
      chk("strobe level", pad_dm_o, 1'b1);
      if (oes[i][9]) chk("strobe in", rx_dm, 1'b1);
    end
    // Mixed phases on a serial base, inside and outside DMA
    foreach (mixes[i]) begin
      x = mixes[i];
      cfg(32'h1, {29'h0, x},
          x[2] ? 32'h10f : x[0] ? 32'h103 : 32'h101);
      foreach (phs[p]) begin
        eng(phs[p], 1'b1, 1'b1);
        w = {x[2], !x[2]};
        if (phs[p] == MSP_PH_INSTR || !x[0]) w = 2'd0;
        if (phs[p] == MSP_PH_ADDR && !x[1]) w = 2'd0;
        chk("mixed width", lane_width, w);
      end
      eng(MSP_PH_DATA, 1'b0, 1'b1);
      chk("plain op width", lane_width, 2'd0);
    end
    // Receive lane 0 source: block drives pad 0 high, device pad 1 low
    for (int s = 0; s < 2; s++) begin
      cfg({27'h0, s[0], 4'h1}, 32'h0, s ? 32'h103 : 32'h101);
      eng(MSP_PH_DATA, 1'b0, 1'b0);
      lw(4);
      chk("receive lane 0", rx_dq[0], !s[0]);
      chk("receive lanes", rx_dq, s ? 8'ha4 : 8'ha5);
      chk("lane data", pad_dq_o, 8'h01);
      chk("clock level", pad_sck_o, 1'b1);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
